// file: pir_pkg.sv
// ==========================================================================
// Shared constants for the interrupt routing block.
package pir_pkg;
   localparam int unsigned PIR_LINES = 16;
   localparam int unsigned PIR_CTL_LINES = 8;
   localparam logic [2:0] PIR_CASCADE_LINE = 3'h2;
   localparam logic [3:0] PIR_REPLACE_LINE = 4'h9;
   localparam logic [7:0] PIR_MASTER_BASE = 8'h08;
   localparam logic [7:0] PIR_SLAVE_BASE = 8'h70;
   localparam logic [7:0] PIR_REPLACE_VECTOR = 8'h71;
   localparam logic [7:0] PIR_LEGACY_VECTOR = 8'h0a;
   localparam logic [15:0] PIR_INPROG_ADDR = 16'h0c00;
   localparam logic [0:0] PIR_INPROG_BIT = 1'h0;
   localparam logic [11:0] PIR_SHARE_PAGE_LO = 12'h02f;
   localparam logic [11:0] PIR_SHARE_PAGE_HI = 12'h06f;
   localparam logic [7:0] PIR_ZERO8 = 8'h00;
   localparam logic [15:0] PIR_ZERO16 = 16'h0000;
   localparam logic PIR_SEL_MASTER = 1'b0;
   localparam logic PIR_SEL_SLAVE = 1'b1;
endpackage : pir_pkg

// file: pir_top.sv
// Behaviour
// [RULE1] PCI lines level-sensitive, ISA lines edge-sensitive.
// [RULE2] End-of-service clears the serviced in-service bit.
// [RULE3] End-of-service accepted with request high or low.
// [RULE4] Level request still high re-requests after end-of-service.
// [RULE5] Handler clears device, delays, ends service, delays.
// [RULE6] In-progress latch readable; read or write clears.
// [RULE7] Legacy cascade request routed to replacement input.
// [RULE8] Replacement input gives vector 71h; legacy is 0Ah.
// [RULE9] Handlers end slave service, then master after drop.
// [RULE10] Sharing reset port writes do not disturb interrupts.
// [RULE11] Slave output drives master cascade input and in-service.
`timescale 1ns/1ps
`default_nettype none
module pir_top
   import pir_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] irq_in,
   input wire logic [15:0] level_sel,
   input wire logic legacy_cascade_request,
   input wire logic int_ack,
   output logic int_req,
   output logic [7:0] vector_ff,
   input wire logic end_of_service_command,
   input wire logic eos_target,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [15:0] io_addr,
   input wire logic read_clears,
   output logic io_ack_ff,
   output logic io_rdata_ff,
   output logic inprog_ff
);
   // =======================================================================
   // Helper functions.
   // Mask of lines whose priority beats every bit set in the in-service word.
   function automatic logic [7:0] allowed(input logic [7:0] isr);
      logic [7:0] m;
      logic hit;
      m = PIR_ZERO8;
      hit = 1'b0;
      for (int i = 0; i < PIR_CTL_LINES; i++) begin
         if (isr[i]) begin
            hit = 1'b1;
         end
         if (!hit) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : allowed

   // Index of the lowest set bit (highest priority).
   function automatic logic [2:0] first(input logic [7:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = PIR_CTL_LINES - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : first

   // =======================================================================
   // Request routing and pending logic.
   logic [15:0] prev_in_ff, nxt_prev_in;
   logic [15:0] irr_edge_ff, nxt_irr_edge;
   logic [7:0] isr_m_ff, nxt_isr_m;
   logic [7:0] isr_s_ff, nxt_isr_s;
   logic [7:0] nxt_vector;
   logic nxt_inprog, nxt_io_ack, nxt_io_rdata;
   logic [15:0] raw;
   logic [15:0] irr;
   logic [7:0] pend_s, pend_m;
   logic slave_out;
   logic inprog_hit, share_hit;

   always_comb begin
      raw = irq_in;
      raw[PIR_REPLACE_LINE] = irq_in[PIR_REPLACE_LINE] | legacy_cascade_request; // RULE7
      irr = (irr_edge_ff & ~level_sel) | (raw & level_sel); // RULE1 RULE4
      pend_s = irr[15:8] & ~isr_s_ff & allowed(isr_s_ff);
      slave_out = |pend_s;
      pend_m = irr[7:0];
      pend_m[PIR_CASCADE_LINE] = slave_out; // RULE11
      pend_m = pend_m & ~isr_m_ff & allowed(isr_m_ff);
      int_req = |pend_m;
      inprog_hit = (io_addr == PIR_INPROG_ADDR);
      share_hit = (io_addr[15:4] == PIR_SHARE_PAGE_LO) ||
         (io_addr[15:4] == PIR_SHARE_PAGE_HI);
   end

   // =======================================================================
   // Next-state computation.
   always_comb begin
      nxt_prev_in = raw;
      nxt_irr_edge = irr_edge_ff;
      nxt_isr_m = isr_m_ff;
      nxt_isr_s = isr_s_ff;
      nxt_vector = vector_ff;
      nxt_inprog = inprog_ff;
      nxt_io_ack = 1'b0;
      nxt_io_rdata = io_rdata_ff;
      if (int_ack && int_req) begin
         if (first(pend_m) == PIR_CASCADE_LINE) begin
            nxt_isr_m[PIR_CASCADE_LINE] = 1'b1; // RULE11
            nxt_isr_s[first(pend_s)] = 1'b1;
            nxt_irr_edge[{1'b1, first(pend_s)}] = 1'b0;
            nxt_vector = PIR_SLAVE_BASE + {5'h00, first(pend_s)}; // RULE8
         end else begin
            nxt_isr_m[first(pend_m)] = 1'b1;
            nxt_irr_edge[{1'b0, first(pend_m)}] = 1'b0;
            nxt_vector = PIR_MASTER_BASE + {5'h00, first(pend_m)}; // RULE8
         end
      end
      // Any end-of-service is taken regardless of line levels.
      // An empty in-service word clears nothing, so that an acknowledge in
      // the same cycle keeps the bit that it sets.
      if (end_of_service_command) begin // RULE3
         if (eos_target == PIR_SEL_SLAVE) begin
            if (isr_s_ff != PIR_ZERO8) begin
               nxt_isr_s[first(isr_s_ff)] = 1'b0; // RULE2
            end
         end else begin
            if (isr_m_ff != PIR_ZERO8) begin
               nxt_isr_m[first(isr_m_ff)] = 1'b0; // RULE2
            end
         end
      end
      // A new edge wins over the acknowledge clear.
      nxt_irr_edge = nxt_irr_edge | (raw & ~prev_in_ff); // RULE1
      if (io_rd || io_wr) begin
         nxt_io_ack = inprog_hit || share_hit; // RULE10
      end
      if (io_rd && inprog_hit) begin
         nxt_io_rdata = inprog_ff; // RULE6
         if (read_clears) begin
            nxt_inprog = 1'b0;
         end
      end
      if (io_wr && inprog_hit) begin
         nxt_inprog = 1'b0; // RULE6
      end
      if (int_ack && int_req) begin
         nxt_inprog = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_in_ff <= PIR_ZERO16;
         irr_edge_ff <= PIR_ZERO16;
         isr_m_ff <= PIR_ZERO8;
         isr_s_ff <= PIR_ZERO8;
         vector_ff <= PIR_ZERO8;
         inprog_ff <= 1'b0;
         io_ack_ff <= 1'b0;
         io_rdata_ff <= 1'b0;
      end else begin
         prev_in_ff <= nxt_prev_in;
         irr_edge_ff <= nxt_irr_edge;
         isr_m_ff <= nxt_isr_m;
         isr_s_ff <= nxt_isr_s;
         vector_ff <= nxt_vector;
         inprog_ff <= nxt_inprog;
         io_ack_ff <= nxt_io_ack;
         io_rdata_ff <= nxt_io_rdata;
      end
   end

   // =======================================================================
   // Assertions.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_edge_latched: assert property ( // RULE1
      $rose(raw[3]) && !level_sel[3]
      |=> irr_edge_ff[3])
      else $error("Edge request on line 3 not latched.");
   a_level_follows: assert property ( // RULE1
      level_sel[5] && !raw[5] && (irr_edge_ff & ~level_sel) == PIR_ZERO16
      && (raw & level_sel) == PIR_ZERO16 |-> !int_req)
      else $error("Dropped level request still pending.");
   a_eos_clears: assert property ( // RULE2
      end_of_service_command && eos_target == PIR_SEL_MASTER
      && isr_m_ff != PIR_ZERO8 && !int_ack
      |=> isr_m_ff == ($past(isr_m_ff) & ($past(isr_m_ff) - 8'h01)))
      else $error("End of service left in-service bit set.");
   a_eos_any_level: assert property ( // RULE3
      end_of_service_command && eos_target == PIR_SEL_SLAVE
      && isr_s_ff[1] && isr_s_ff[0] == 1'b0 && !int_ack |=> !isr_s_ff[1])
      else $error("Slave end of service ignored.");
   a_level_rerequest: assert property ( // RULE4
      level_sel[5] && raw[5] && isr_m_ff == 8'h20 && end_of_service_command
      && eos_target == PIR_SEL_MASTER && !int_ack
      ##1 level_sel[5] && raw[5] |-> int_req)
      else $error("Held level request not seen again.");
   a_inprog_set: assert property ( // RULE6
      int_ack && int_req |=> inprog_ff)
      else $error("In-progress latch not set.");
   a_inprog_wrclr: assert property ( // RULE6
      io_wr && inprog_hit && !(int_ack && int_req)
      |=> !inprog_ff && io_ack_ff)
      else $error("Write did not clear in-progress latch.");
   a_inprog_rdclr: assert property ( // RULE6
      io_rd && inprog_hit && read_clears && !(int_ack && int_req)
      |=> !inprog_ff && io_ack_ff)
      else $error("Read did not clear in-progress latch.");
   a_legacy_vector: assert property ( // RULE7
      legacy_cascade_request && int_ack && int_req && irq_in == PIR_ZERO16
      && isr_m_ff == PIR_ZERO8 && isr_s_ff == PIR_ZERO8
      && (irr_edge_ff & ~(16'h0001 << PIR_REPLACE_LINE)) == PIR_ZERO16
      |=> vector_ff == PIR_REPLACE_VECTOR)
      else $error("Legacy cascade request gave wrong vector."); // RULE8
   a_share_quiet: assert property ( // RULE10
      io_wr && share_hit && !int_ack && !end_of_service_command
      |=> $stable(isr_m_ff) && $stable(isr_s_ff) && $stable(inprog_ff))
      else $error("Sharing reset write disturbed interrupts.");
   a_cascade_isr: assert property ( // RULE11
      isr_s_ff != PIR_ZERO8 |-> isr_m_ff[PIR_CASCADE_LINE])
      else $error("Slave in service without master cascade bit.");

   c_slave_ack: cover property (int_ack && int_req
      && first(pend_m) == PIR_CASCADE_LINE);
   c_level_reissue: cover property (end_of_service_command ##1 int_req);
   c_share_write: cover property (io_wr && share_hit);
   c_set_beats_clear: cover property (int_ack && io_wr && inprog_hit);
endmodule : pir_top
`default_nettype wire

// file: pir_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Processor side: takes a pending request with one pulse.
module pir_host_model (
   input wire logic clk,
   input wire logic en,
   input wire logic int_req,
   output logic int_ack
);
   logic ack_ff = 1'b0;
   // The idle cycle after each pulse lets the design drop its request.
   always @(posedge clk) begin
      ack_ff <= en && int_req && !ack_ff;
   end
   assign int_ack = ack_ff;
endmodule : pir_host_model
`default_nettype wire

// file: pc_interrupt_routing_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin \
   n_checks++; \
   if ((a) !== (e)) begin \
      n_fail++; \
      $display("ERROR %s expected %h seen %h", nm, e, a); \
   end \
end
// ==========================================================
// Bench for the interrupt routing block.
module pc_interrupt_routing_test
   import pir_pkg::*;
();
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic lcr = 1'b0;
   logic eos = 1'b0;
   logic tgt = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic rclr = 1'b0;
   logic host_en = 1'b0;
   logic [15:0] irq = 16'h0000;
   logic [15:0] lsel = 16'h0000;
   logic [15:0] addr = 16'h0000;
   logic int_ack, int_req, io_ack, io_rdata, inprog;
   logic [7:0] vec;
   int n_fail = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   pir_top DUT (.clk(clk), .resetn(resetn), .irq_in(irq),
      .level_sel(lsel), .legacy_cascade_request(lcr),
      .int_ack(int_ack), .int_req(int_req), .vector_ff(vec),
      .end_of_service_command(eos), .eos_target(tgt),
      .io_rd(rd), .io_wr(wr), .io_addr(addr),
      .read_clears(rclr), .io_ack_ff(io_ack),
      .io_rdata_ff(io_rdata), .inprog_ff(inprog));
   pir_host_model host (.clk(clk), .en(host_en),
      .int_req(int_req), .int_ack(int_ack));
   // ==========================================================
   // Shared tasks.
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   task automatic send_eos(input logic t);
      tgt = t;
      eos = 1'b1;
      @(negedge clk);
      eos = 1'b0;
      @(negedge clk);
   endtask : send_eos
   task automatic take_ack(input logic [7:0] exp);
      int k;
      k = 0;
      host_en = 1'b1;
      while (int_ack !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      host_en = 1'b0;
      @(negedge clk);
      `CHK("vector", exp, vec)
   endtask : take_ack
   task automatic io_op(input logic w, input logic [15:0] a,
         input logic exp);
      addr = a;
      wr = w;
      rd = !w;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      `CHK("io ack", exp, io_ack)
      @(negedge clk);
   endtask : io_op
   // ==========================================================
   // Scenarios.
   task automatic t_trigger;
      irq[3] = 1'b1;
      take_ack(PIR_MASTER_BASE + 8'h03);
      `CHK("inprog", 1'b1, inprog)
      send_eos(PIR_SEL_MASTER);
      `CHK("edge held", 1'b0, int_req)
      irq[3] = 1'b0;
      lsel[5] = 1'b1;
      irq[5] = 1'b1;
      take_ack(PIR_MASTER_BASE + 8'h05);
      `CHK("in service", 1'b0, int_req)
      send_eos(PIR_SEL_MASTER);
      `CHK("level again", 1'b1, int_req)
      irq[5] = 1'b0;
      @(negedge clk);
      `CHK("level drop", 1'b0, int_req)
      irq[5] = 1'b1;
      take_ack(PIR_MASTER_BASE + 8'h05);
      irq[5] = 1'b0;
      @(negedge clk);
      send_eos(PIR_SEL_MASTER);
      `CHK("handler order", 1'b0, int_req)
   endtask : t_trigger
   task automatic t_cascade;
      lcr = 1'b1;
      take_ack(PIR_REPLACE_VECTOR);
      send_eos(PIR_SEL_SLAVE);
      lcr = 1'b0;
      lsel[10] = 1'b1;
      irq[10] = 1'b1;
      @(negedge clk);
      `CHK("slave blocked", 1'b0, int_req)
      send_eos(PIR_SEL_MASTER);
      take_ack(PIR_SLAVE_BASE + 8'h02);
      irq[10] = 1'b0;
      send_eos(PIR_SEL_SLAVE);
      send_eos(PIR_SEL_MASTER);
   endtask : t_cascade
   task automatic t_io;
      io_op(1'b0, PIR_INPROG_ADDR, 1'b1);
      `CHK("latch read", 1'b1, io_rdata)
      `CHK("latch kept", 1'b1, inprog)
      irq[4] = 1'b1;
      io_op(1'b1, 16'h02f4, 1'b1);
      io_op(1'b1, 16'h06f9, 1'b1);
      `CHK("share int", 1'b1, int_req)
      `CHK("share latch", 1'b1, inprog)
      io_op(1'b0, 16'h0123, 1'b0);
      rclr = 1'b1;
      io_op(1'b0, PIR_INPROG_ADDR, 1'b1);
      `CHK("read clear", 1'b0, inprog)
      take_ack(PIR_MASTER_BASE + 8'h04);
      io_op(1'b1, PIR_INPROG_ADDR, 1'b1);
      `CHK("write clear", 1'b0, inprog)
   endtask : t_io
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      `CHK("reset req", 1'b0, int_req)
      `CHK("reset vec", 8'h00, vec)
      t_trigger();
      t_cascade();
      t_io();
      summarize();
   end
   initial begin
      #(100 * 2000);
      n_fail++;
      summarize();
   end
endmodule : pc_interrupt_routing_test
`default_nettype wire
